//--- afr_flag_regs.sv
// Purpose: Channel-3 alarm byte, reserved byte and fast-trip flag byte
// Assumes: Byte register port driven by the serial interface on clk
// Notes:   Read data is registered; answers one cycle after the strobe
//
// Summary of operation
// - Channel-3 high alarm bit 7 is 1 when measurement exceeds high limit.
// - Channel-3 low alarm bit 6 is 1 when measurement is below low limit.
// - Channel-3 flag byte is volatile and meaningless before first conversion.
// - Summary bit 0 and output pin are OR of all unmasked flags.
// - Mask bytes come from one of two tables chosen by mask-select bit.
// - All mask bytes set to suppress forces the summary to zero.
// - Fast-trip flag byte powers up as zero, held in volatile storage.
// - Latched fast-trip flags hold until host writes zero to that bit.
// - Upper three bits of the fast-trip byte always read zero.
// - Bias warning trip flag is 1 above warning limit, else 0.
// - Bias alarm trip flag is 1 above alarm limit, else 0.
// - Signal-loss trip flag is 1 below its limit, else 0.
// - Low transmit power trip flag is 1 below its limit, else 0.
// - High transmit power trip flag is 1 above its limit, else 0.

`timescale 1ns/1ns

module afr_flag_regs (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              reset,
  // Byte register port
  input  wire logic [7:0]                        reg_addr,
  input  wire logic                              reg_wr_en,
  input  wire logic [7:0]                        reg_wr_data,
  input  wire logic                              reg_rd_en,
  output logic      [7:0]                        reg_rd_data,
  output logic                                   reg_rd_valid,
  // Third monitor channel conversion
  input  wire logic                              ch3_result_valid,
  input  wire logic [afr_pkg::MEAS_W-1:0]        ch3_result,
  input  wire logic [afr_pkg::MEAS_W-1:0]        ch3_high_limit,
  input  wire logic [afr_pkg::MEAS_W-1:0]        ch3_low_limit,
  // Other alarm and warning flag bytes
  input  wire logic [7:0]                        alarm_flags_main,
  input  wire logic [7:0]                        warning_flags_main,
  input  wire logic [7:0]                        warning_flags_ch3,
  // Mask tables and selection
  input  wire logic [afr_pkg::FLAG_W-1:0]        mask_table_prim,
  input  wire logic [afr_pkg::FLAG_W-1:0]        mask_table_alt,
  input  wire logic                              mask_select,
  // Fast-trip comparators
  input  wire logic [afr_pkg::TRIP_W-1:0]        trip_cmp_raw,
  input  wire logic                              trip_latch_en,
  // Flag outputs
  output logic                                   masked_interrupt_summary,
  output logic                                   ch3_high_alarm_flag,
  output logic                                   ch3_low_alarm_flag,
  output logic                                   ch3_converted,
  output logic      [afr_pkg::TRIP_W-1:0]        trip_flags
);

  // Channel-3 comparison values
  logic ch3_high_next;
  logic ch3_low_next;

  // Fast-trip flags and their next values
  logic [afr_pkg::TRIP_W-1:0] trip_next;
  logic [afr_pkg::TRIP_W-1:0] trip_clear;

  // Summary and read path
  logic                       summary_reg;
  logic                       summary_next;
  logic [7:0]                 rd_data_reg;
  logic                       rd_valid_reg;

  // Address decode
  wire                        hit_ch3  = (reg_addr == afr_pkg::ADDR_CH3_FLAGS);
  wire                        hit_rsvd = (reg_addr == afr_pkg::ADDR_RSVD);
  wire                        hit_trip = (reg_addr == afr_pkg::ADDR_TRIP);
  wire                        wr_trip  = reg_wr_en && hit_trip;

  // Channel-3 alarm comparator
  afr_ch3_cmp u_ch3 (
    .clk           (clk),
    .reset         (reset),
    .result_valid  (ch3_result_valid),
    .result        (ch3_result),
    .high_limit    (ch3_high_limit),
    .low_limit     (ch3_low_limit),
    .high_next     (ch3_high_next),
    .low_next      (ch3_low_next),
    .high_reg      (ch3_high_alarm_flag),
    .low_reg       (ch3_low_alarm_flag),
    .converted_reg (ch3_converted)
  );

  // Fast-trip flags, one per comparator; a written zero clears a latched bit
  genvar gi;
  generate
    for (gi = 0; gi < afr_pkg::TRIP_W; gi++) begin : g_trip
      assign trip_clear[gi] = wr_trip && !reg_wr_data[gi];
      afr_trip_flag u_trip (
        .clk       (clk),
        .reset     (reset),
        .cmp_raw   (trip_cmp_raw[gi]),
        .latch_en  (trip_latch_en),
        .clear     (trip_clear[gi]),
        .flag_next (trip_next[gi]),
        .flag_reg  (trip_flags[gi])
      );
    end
  endgenerate

  // Active mask table picked by the select bit
  wire [afr_pkg::FLAG_W-1:0] active_mask =
    (mask_select == afr_pkg::MASK_SEL_ALT) ? mask_table_alt : mask_table_prim;

  // Channel-3 byte as an interrupt source; bit 0 is the summary itself, not a source
  wire [7:0] ch3_src_next = {ch3_high_next, ch3_low_next, 6'h00};

  // Sources ordered like the mask bytes: main alarm, ch3 alarm, main warning, ch3 warning
  wire [afr_pkg::FLAG_W-1:0] flag_vec_next =
    {alarm_flags_main, ch3_src_next, warning_flags_main, warning_flags_ch3};

  // Summary from next flag values so it lands with the flags; mask bit 1 suppresses
  assign summary_next = |(flag_vec_next & ~active_mask);

  // Read bytes; unused positions forced to zero
  wire [7:0] ch3_byte  = {ch3_high_alarm_flag, ch3_low_alarm_flag, 5'h00, summary_reg};
  wire [7:0] trip_byte = {3'h0, trip_flags};
  wire [7:0] rd_mux    = hit_ch3  ? ch3_byte  :
                         hit_trip ? trip_byte :
                         afr_pkg::BYTE_ZERO;

  // Summary flop; writes to ch3 or reserved bytes have no effect
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      summary_reg <= afr_pkg::FLAG_RESET;
    end else begin
      summary_reg <= summary_next;
    end
  end

  // Read data held until the next read strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data_reg  <= afr_pkg::BYTE_RESET;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= reg_rd_en;
      if (reg_rd_en) begin
        rd_data_reg <= rd_mux;
      end
    end
  end

  assign masked_interrupt_summary = summary_reg;
  assign reg_rd_data              = rd_data_reg;
  assign reg_rd_valid             = rd_valid_reg;

  // Helper: pending unmasked source seen by the summary
  wire pending = summary_next;

  summary_src_a: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> (masked_interrupt_summary == $past(pending)))
    else $error("summary output does not match unmasked flags");

  summary_mask_a: assert property (@(posedge clk) disable iff (reset)
    (&active_mask) |=> !masked_interrupt_summary)
    else $error("summary raised with every mask set");

  mask_sel_a: assert property (@(posedge clk) disable iff (reset)
    (mask_select && (&mask_table_alt)) |=> !masked_interrupt_summary)
    else $error("alternative mask table not applied");

  prim_sel_a: assert property (@(posedge clk) disable iff (reset)
    (!mask_select && (&mask_table_prim)) |=> !masked_interrupt_summary)
    else $error("primary mask table not applied");

  summary_now_a: assert property (@(posedge clk) disable iff (reset)
    (ch3_result_valid && (ch3_result > ch3_high_limit) && !active_mask[23])
      |=> (masked_interrupt_summary && ch3_high_alarm_flag))
    else $error("summary lags the alarm flag update");

  rsvd_read_a: assert property (@(posedge clk) disable iff (reset)
    (reg_rd_en && hit_rsvd) |=> (reg_rd_valid && (reg_rd_data == 8'h00)))
    else $error("reserved byte read not zero");

  ch3_rsvd_a: assert property (@(posedge clk) disable iff (reset)
    (reg_rd_en && hit_ch3) |=> (reg_rd_data[5:1] == 5'h00))
    else $error("reserved channel-3 bits read not zero");

  ch3_read_a: assert property (@(posedge clk) disable iff (reset)
    (reg_rd_en && hit_ch3) |=> (reg_rd_data[7] == $past(ch3_high_alarm_flag)
                               && reg_rd_data[6] == $past(ch3_low_alarm_flag)))
    else $error("channel-3 alarm bits read wrong");

  trip_upper_a: assert property (@(posedge clk) disable iff (reset)
    (reg_rd_en && hit_trip) |=> (reg_rd_data[7:5] == 3'h0
                                && reg_rd_data[4:0] == $past(trip_flags)))
    else $error("fast-trip byte read wrong");

  trip_path_a: assert property (@(posedge clk) disable iff (reset)
    (!trip_latch_en && trip_cmp_raw[afr_pkg::TRIP_BIAS_ALM]) [*4]
      |-> trip_flags[afr_pkg::TRIP_BIAS_ALM])
    else $error("bias alarm trip flag not set after synchroniser");

  sig_loss_path_a: assert property (@(posedge clk) disable iff (reset)
    (!trip_latch_en && !trip_cmp_raw[afr_pkg::TRIP_SIG_LOSS]) [*4]
      |-> !trip_flags[afr_pkg::TRIP_SIG_LOSS])
    else $error("signal-loss trip flag not cleared by comparator");

  // Unmapped offsets read zero; bit 0 of the channel-3 byte carries the summary
  unmapped_read_a: assert property (@(posedge clk) disable iff (reset)
    (reg_rd_en && !hit_ch3 && !hit_rsvd && !hit_trip) |=> (reg_rd_data == afr_pkg::BYTE_ZERO))
    else $error("unmapped offset read not zero");

  ch3_sum_read_a: assert property (@(posedge clk) disable iff (reset)
    (reg_rd_en && hit_ch3) |=> (reg_rd_data[afr_pkg::SUMMARY_BIT] == $past(masked_interrupt_summary)))
    else $error("channel-3 summary bit read wrong");

  // Read port: one answer per strobe, data held between reads so a slow host can re-sample
  rd_valid_a: assert property (@(posedge clk) disable iff (reset)
    reg_rd_en |=> reg_rd_valid)
    else $error("read strobe not answered");

  rd_idle_a: assert property (@(posedge clk) disable iff (reset)
    !reg_rd_en |=> !reg_rd_valid)
    else $error("read answer without a strobe");

  rd_hold_a: assert property (@(posedge clk) disable iff (reset)
    !reg_rd_en |=> $stable(reg_rd_data))
    else $error("read data moved without a strobe");

  // Writes land only in the fast-trip byte; everything else is dropped
  ch3_wr_ignore_a: assert property (@(posedge clk) disable iff (reset)
    (reg_wr_en && hit_ch3 && !ch3_result_valid) |=> ($stable(ch3_high_alarm_flag) && $stable(ch3_low_alarm_flag)))
    else $error("write to channel-3 byte moved an alarm flag");

  other_wr_ignore_a: assert property (@(posedge clk) disable iff (reset)
    (reg_wr_en && !hit_trip && trip_latch_en) |=> (($past(trip_flags) & ~trip_flags) == 5'h00))
    else $error("latched trip flag cleared by a write elsewhere");

  // A stored result marks the channel-3 byte as meaningful until the next reset
  converted_set_a: assert property (@(posedge clk) disable iff (reset)
    ch3_result_valid |=> ch3_converted)
    else $error("conversion marker not set by a stored result");

  converted_keep_a: assert property (@(posedge clk) disable iff (reset)
    ch3_converted |=> ch3_converted)
    else $error("conversion marker dropped");

  // Summary raised by any unmasked source, kept low when nothing is pending
  summary_raise_a: assert property (@(posedge clk) disable iff (reset)
    (|(alarm_flags_main & ~active_mask[31:24])) |=> masked_interrupt_summary)
    else $error("unmasked alarm did not raise the summary");

  warn_raise_a: assert property (@(posedge clk) disable iff (reset)
    ((|(warning_flags_main & ~active_mask[15:8])) || (|(warning_flags_ch3 & ~active_mask[7:0])))
      |=> masked_interrupt_summary)
    else $error("unmasked warning did not raise the summary");

  summary_quiet_a: assert property (@(posedge clk) disable iff (reset)
    (flag_vec_next == 32'h00000000) |=> !masked_interrupt_summary)
    else $error("summary raised with no pending source");

  low_now_a: assert property (@(posedge clk) disable iff (reset)
    (ch3_result_valid && (ch3_result < ch3_low_limit) && !active_mask[22])
      |=> (masked_interrupt_summary && ch3_low_alarm_flag))
    else $error("summary lags the low alarm flag update");

  ch3_high_keep_a: assert property (@(posedge clk) disable iff (reset)
    (!ch3_result_valid && ch3_high_alarm_flag && !active_mask[23])
      |=> masked_interrupt_summary)
    else $error("summary dropped while high alarm stands");

  ch3_low_keep_a: assert property (@(posedge clk) disable iff (reset)
    (!ch3_result_valid && ch3_low_alarm_flag && !active_mask[22])
      |=> masked_interrupt_summary)
    else $error("summary dropped while low alarm stands");

  // Per trip bit: follow or latch the synchronised comparator, clear on a written zero
  generate
    for (gi = 0; gi < afr_pkg::TRIP_W; gi++) begin : g_trip_chk
      trip_rise_a: assert property (@(posedge clk) disable iff (reset)
        (!trip_latch_en && trip_cmp_raw[gi]) [*4] |-> trip_flags[gi])
        else $error("unlatched trip flag not set by comparator");

      trip_fall_a: assert property (@(posedge clk) disable iff (reset)
        (!trip_latch_en && !trip_cmp_raw[gi]) [*4] |-> !trip_flags[gi])
        else $error("unlatched trip flag not cleared by comparator");

      trip_set_a: assert property (@(posedge clk) disable iff (reset)
        (trip_latch_en && trip_cmp_raw[gi]) [*4] |-> trip_flags[gi])
        else $error("latched trip flag not set by comparator");

      trip_wr_one_a: assert property (@(posedge clk) disable iff (reset)
        (trip_latch_en && wr_trip && reg_wr_data[gi] && trip_flags[gi]) |=> trip_flags[gi])
        else $error("written one cleared a latched trip flag");

      trip_wr_zero_a: assert property (@(posedge clk) disable iff (reset)
        (trip_latch_en && !trip_cmp_raw[gi]) [*3] ##0 (wr_trip && !reg_wr_data[gi]) |=> !trip_flags[gi])
        else $error("written zero did not clear an idle trip flag");
    end
  endgenerate

endmodule // afr_flag_regs

//--- afr_pkg.sv
// Purpose: Shared constants for the alarm and fast-trip flag register block
// Assumes: Byte-wide register port fed by the serial interface logic
// Notes:   Offsets, bit positions and reset values live here only

package afr_pkg;

  // Register offsets on the byte port
  localparam logic [7:0] ADDR_CH3_FLAGS = 8'h71;
  localparam logic [7:0] ADDR_RSVD      = 8'h72;
  localparam logic [7:0] ADDR_TRIP      = 8'h73;

  // Measurement and limit width of the third monitor channel
  localparam int MEAS_W = 16;

  // Bit positions in the channel-3 flag byte
  localparam int CH3_HI_BIT  = 7;
  localparam int CH3_LO_BIT  = 6;
  localparam int SUMMARY_BIT = 0;

  // Fast-trip flag byte layout
  localparam int TRIP_W         = 5;
  localparam int TRIP_BIAS_WARN = 4;
  localparam int TRIP_BIAS_ALM  = 3;
  localparam int TRIP_SIG_LOSS  = 2;
  localparam int TRIP_LOW_TXP   = 1;
  localparam int TRIP_HIGH_TXP  = 0;

  // Interrupt source vector: four flag bytes, one mask byte each
  localparam int FLAG_W = 32;

  // Value of the mask-select bit that picks the alternative table
  localparam logic MASK_SEL_ALT = 1'b1;

  // Values after reset
  localparam logic [TRIP_W-1:0] TRIP_RESET = 5'h00;
  localparam logic              FLAG_RESET = 1'b0;
  localparam logic [7:0]        BYTE_RESET = 8'h00;
  localparam logic [7:0]        BYTE_ZERO  = 8'h00;

endpackage

//--- afr_ch3_cmp.sv
// Purpose: Third monitor channel high and low alarm comparison
// Assumes: Result, limits and valid strobe come from logic on clk
// Notes:   Flags only move when a new conversion result is stored

`timescale 1ns/1ns

module afr_ch3_cmp (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // Conversion result and limits
  input  wire logic                       result_valid,
  input  wire logic [afr_pkg::MEAS_W-1:0] result,
  input  wire logic [afr_pkg::MEAS_W-1:0] high_limit,
  input  wire logic [afr_pkg::MEAS_W-1:0] low_limit,
  // Flag values
  output logic                            high_next,
  output logic                            low_next,
  output logic                            high_reg,
  output logic                            low_reg,
  output logic                            converted_reg
);

  // New values on a stored result, else hold
  assign high_next = result_valid ? (result > high_limit) : high_reg;
  assign low_next  = result_valid ? (result < low_limit) : low_reg;

  // Flags are plain volatile flops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      high_reg      <= afr_pkg::FLAG_RESET;
      low_reg       <= afr_pkg::FLAG_RESET;
      converted_reg <= afr_pkg::FLAG_RESET;
    end else begin
      high_reg      <= high_next;
      low_reg       <= low_next;
      converted_reg <= converted_reg | result_valid;
    end
  end

  hi_cmp_a: assert property (@(posedge clk) disable iff (reset)
    result_valid |=> (high_reg == $past(result > high_limit)))
    else $error("high alarm flag does not match comparison");

  lo_cmp_a: assert property (@(posedge clk) disable iff (reset)
    result_valid |=> (low_reg == $past(result < low_limit)))
    else $error("low alarm flag does not match comparison");

  flag_hold_a: assert property (@(posedge clk) disable iff (reset)
    !result_valid |=> ($stable(high_reg) && $stable(low_reg)))
    else $error("alarm flag moved without a new result");

endmodule // afr_ch3_cmp

//--- afr_trip_flag.sv
// Purpose: One fast-trip flag with synchroniser and optional latch
// Assumes: Comparator output is asynchronous to clk
// Notes:   A comparator set beats a software clear in the same cycle

`timescale 1ns/1ns

module afr_trip_flag (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Comparator and control
  input  wire logic cmp_raw,
  input  wire logic latch_en,
  input  wire logic clear,
  // Flag
  output logic      flag_next,
  output logic      flag_reg
);

  logic sync1_reg;
  logic sync2_reg;

  // Latched: set wins over clear; transparent: follow comparator
  assign flag_next = latch_en ? (sync2_reg | (flag_reg & ~clear)) : sync2_reg;

  // Two-stage synchroniser then the flag itself
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_reg <= afr_pkg::FLAG_RESET;
      sync2_reg <= afr_pkg::FLAG_RESET;
      flag_reg  <= afr_pkg::FLAG_RESET;
    end else begin
      sync1_reg <= cmp_raw;
      sync2_reg <= sync1_reg;
      flag_reg  <= flag_next;
    end
  end

  trip_follow_a: assert property (@(posedge clk) disable iff (reset)
    !latch_en |=> (flag_reg == $past(sync2_reg)))
    else $error("unlatched trip flag does not follow comparator");

  trip_latch_a: assert property (@(posedge clk) disable iff (reset)
    (latch_en && flag_reg && !clear) |=> flag_reg)
    else $error("latched trip flag dropped without a clear");

  trip_clear_a: assert property (@(posedge clk) disable iff (reset)
    (latch_en && clear && !sync2_reg) |=> !flag_reg)
    else $error("latched trip flag not cleared by write of zero");

endmodule // afr_trip_flag

//--- afr_host_model.sv
// Purpose: Host side of the byte register port
// Assumes: Requests launch at rising clk by non-blocking assignment
// Notes:   Write data is scrambled when idle so stale bytes never look valid

`timescale 1ns/1ns

module afr_host_model (
  // Clock
  input  wire logic       clk,
  // Byte register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wr_data,
  output logic            reg_rd_en,
  input  wire logic [7:0] reg_rd_data,
  input  wire logic       reg_rd_valid
);
  // Idle port at time zero
  initial begin
    reg_addr    = 8'h00;
    reg_wr_en   = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en   = 1'b0;
  end

  // One-cycle read strobe, answer taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    v = reg_rd_valid;
    d = reg_rd_data;
  endtask

  // Single byte write; zero bits clear latched trip flags
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'b1;
    @(posedge clk);
    reg_wr_en   <= 1'b0;
    reg_wr_data <= ~d;
  endtask
endmodule // afr_host_model

//--- testbench.sv
// Purpose: Self-checking bench for the alarm and fast-trip flag registers
// Assumes: Trip comparators settle through the synchroniser within 5 cycles
// Notes:   Expected values come from a small integer model kept here

`timescale 1ns/1ns

module testbench;
  // Clock, reset and design inputs
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        ch3_result_valid = 1'b0;
  logic [15:0] ch3_result = 16'h0000, ch3_high_limit = 16'h0000, ch3_low_limit = 16'h0000;
  logic [7:0]  alarm_flags_main = 8'h00, warning_flags_main = 8'h00, warning_flags_ch3 = 8'h00;
  logic [31:0] mask_table_prim = 32'h00000000, mask_table_alt = 32'h00000000;
  logic        mask_select = 1'b0, trip_latch_en = 1'b0;
  logic [4:0]  trip_cmp_raw = 5'h00;
  // Design outputs and port wiring
  wire  [7:0]  reg_addr, reg_wr_data, reg_rd_data;
  wire         reg_wr_en, reg_rd_en, reg_rd_valid;
  wire         summary, hi_flag, lo_flag, converted;
  wire  [4:0]  trip_flags;
  // Bench state
  int          error_cnt = 0, tests_run = 0, cyc = 0;
  logic [31:0] seed = 32'h00000009;
  logic [4:0]  exp_trip;
  logic        eh, el, es;

  always #5 clk = ~clk;

  afr_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid));

  afr_flag_regs DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .ch3_result_valid(ch3_result_valid), .ch3_result(ch3_result), .ch3_high_limit(ch3_high_limit),
    .ch3_low_limit(ch3_low_limit), .alarm_flags_main(alarm_flags_main), .warning_flags_main(warning_flags_main),
    .warning_flags_ch3(warning_flags_ch3), .mask_table_prim(mask_table_prim), .mask_table_alt(mask_table_alt),
    .mask_select(mask_select), .trip_cmp_raw(trip_cmp_raw), .trip_latch_en(trip_latch_en),
    .masked_interrupt_summary(summary), .ch3_high_alarm_flag(hi_flag), .ch3_low_alarm_flag(lo_flag),
    .ch3_converted(converted), .trip_flags(trip_flags));

  // Fixed-seed xorshift source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Byte comparison, also used for flag outputs packed into a byte
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read through the host and compare byte and answer strobe
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    chk8({7'h00, v}, 8'h01);
    chk8(d, exp);
  endtask

  // Trip byte seen both on the port and through the register
  task automatic tripchk();
    #1;
    chk8({3'h0, trip_flags}, {3'h0, exp_trip});
    rdchk(afr_pkg::ADDR_TRIP, {3'h0, exp_trip});
  endtask

  // Comparator change, then wait out the synchroniser
  task automatic set_trip(input logic [4:0] v);
    @(posedge clk);
    trip_cmp_raw <= v;
    repeat (5) @(posedge clk);
    exp_trip = trip_latch_en ? (exp_trip | v) : v;
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard, well above the roughly 600 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    logic [15:0] res, hl, ll;
    logic [31:0] msk;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    exp_trip = 5'h00;
    chk8({7'h00, converted}, 8'h00);
    tripchk();
    // Each trip source in follow and latch modes, then clear by writing zero
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      trip_latch_en <= m[0];
      @(posedge clk);
      for (int i = 0; i < 5; i++) begin
        set_trip(5'h01 << i);
        tripchk();
        set_trip(5'h00);
        tripchk();
        host.wr(afr_pkg::ADDR_TRIP, 8'hFF);
        tripchk();
        host.wr(afr_pkg::ADDR_TRIP, ~(8'h01 << i));
        exp_trip = exp_trip & ~(5'h01 << i);
        tripchk();
      end
    end
    // Clear while comparators still trip: flags stay set
    set_trip(5'h1F);
    host.wr(afr_pkg::ADDR_TRIP, 8'h00);
    tripchk();
    set_trip(5'h00);
    host.wr(afr_pkg::ADDR_TRIP, 8'h00);
    exp_trip = 5'h00;
    tripchk();
    // Random channel-3 results, other flags, masks and table choice
    for (int k = 0; k < 60; k++) begin
      @(posedge clk);
      hl  = 16'(xs());
      ll  = 16'(xs());
      res = (k % 8 == 0) ? hl : (k % 8 == 1) ? ll : 16'(xs());
      ch3_high_limit     <= hl;
      ch3_low_limit      <= ll;
      ch3_result         <= res;
      ch3_result_valid   <= 1'b1;
      alarm_flags_main   <= 8'(xs());
      warning_flags_main <= (k % 3 == 0) ? 8'(xs()) : 8'h00;
      warning_flags_ch3  <= (k % 4 == 0) ? 8'(xs()) : 8'h00;
      mask_table_prim    <= (k % 5 == 0) ? 32'hFFFFFFFF : xs();
      mask_table_alt     <= (k % 5 == 0) ? 32'hFFFFFFFF : xs();
      msk = xs();
      mask_select        <= msk[0];
      @(posedge clk);
      ch3_result_valid <= 1'b0;
      @(posedge clk);
      #1;
      eh  = res > ch3_high_limit;
      el  = res < ch3_low_limit;
      msk = (mask_select === afr_pkg::MASK_SEL_ALT) ? mask_table_alt : mask_table_prim;
      es  = |({alarm_flags_main, eh, el, 6'h00, warning_flags_main, warning_flags_ch3} & ~msk);
      chk8({5'h00, hi_flag, lo_flag, summary}, {5'h00, eh, el, es});
      chk8({7'h00, converted}, 8'h01);
      rdchk(afr_pkg::ADDR_CH3_FLAGS, {eh, el, 5'h00, es});
    end
    // Reserved byte, read-only flag byte and an unmapped offset
    host.wr(afr_pkg::ADDR_RSVD, 8'hFF);
    rdchk(afr_pkg::ADDR_RSVD, 8'h00);
    host.wr(afr_pkg::ADDR_CH3_FLAGS, 8'h3E);
    rdchk(afr_pkg::ADDR_CH3_FLAGS, {eh, el, 5'h00, es});
    rdchk(8'h70, 8'h00);
    end_of_test();
  end
endmodule // testbench
